// [hw/pad_autodetect.sv]
// Start-count based presence and source autodetect for the controller
module pad_autodetect
  import pad_pkg::*;
#(
  parameter int unsigned WIN_CYC = DETECT_WINDOW_CYC,
  parameter int unsigned FLS_CYC = FLS_WINDOW_CYC,
  parameter int unsigned CAL_LEVELS = NUM_CAL_LEVELS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin inputs, asynchronous to clk
  input wire logic engine_start,
  input wire logic retarder_pressure_solenoid_seen,
  input wire logic fluid_level_sensor_above,
  input wire logic throttle_position_sensor_seen,
  input wire logic throttle_j1587_seen,
  input wire logic throttle_j1939_seen,
  input wire logic coolant_sensor_seen,
  input wire logic coolant_j1939_seen,
  input wire logic coolant_j1587_seen,
  input wire logic hardware_config_id_hsd_tied,
  input wire logic [1:0] hardware_config_id,
  // Service tool commands, one-cycle pulses on clk
  input wire logic reset_all_cmd,
  input wire logic reset_retarder_cmd,
  input wire logic shift_learning_clear_command,
  input wire logic customer_constant_write,
  input wire logic [1:0] customer_constant_item,
  input wire logic [1:0] customer_constant_value,
  // Results
  output logic retarder_present,
  output logic retarder_done,
  output logic fls_present,
  output logic fls_done,
  output logic fls_diag_enable,
  output logic [1:0] throttle_source,
  output logic throttle_done,
  output logic [1:0] coolant_source,
  output logic coolant_done,
  output logic [1:0] cal_level,
  output logic cal_missing_code,
  output logic window_active
);
  // Elaboration checks on the parameters
  if (WIN_CYC < 2 || FLS_CYC < 1 || FLS_CYC > WIN_CYC || WIN_CYC >= 2**29)
    $error("pad_autodetect: window parameters out of range");
  if (CAL_LEVELS < 1 || CAL_LEVELS > 4)
    $error("pad_autodetect: CAL_LEVELS must be 1 to 4");

  localparam logic [28:0] WIN_LAST = 29'(WIN_CYC - 1);
  localparam logic [28:0] FLS_LIM = 29'(FLS_CYC);

  // Highest priority set bit; bit 0 ranks first
  function automatic logic [1:0] pick_src(input logic [2:0] v);
    logic [1:0] r;
    r = SRC_NONE;
    if (v[2]) r = 2'h3;
    if (v[1]) r = 2'h2;
    if (v[0]) r = 2'h1;
    return r;
  endfunction

  // Consecutive counter step, saturating at the flag count
  function automatic logic [2:0] cons_step(input logic [2:0] c,
                                           input logic seen);
    logic [2:0] r;
    r = CNT3_RST;
    if (seen) r = (c >= CONF_CONSEC) ? CONF_CONSEC : 3'(c + 3'h1);
    return r;
  endfunction

  // Two-flop synchronisers for all pin inputs
  logic [11:0] pin_raw, sync1_q, sync2_q;
  assign pin_raw = {hardware_config_id, hardware_config_id_hsd_tied,
                    coolant_j1587_seen, coolant_j1939_seen,
                    coolant_sensor_seen, throttle_j1939_seen,
                    throttle_j1587_seen, throttle_position_sensor_seen,
                    fluid_level_sensor_above,
                    retarder_pressure_solenoid_seen, engine_start};
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= 12'h000;
      sync2_q <= 12'h000;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  // Start edge, taken from the second synchroniser stage only
  logic start_prev_q, start_pulse;
  always_ff @(posedge clk) begin
    if (rst) start_prev_q <= 1'b0;
    else start_prev_q <= sync2_q[0];
  end
  assign start_pulse = sync2_q[0] & ~start_prev_q;

  // Per-start window; a new start restarts it and drops the old one
  logic [28:0] win_cnt_q;
  logic win_q, eval;
  assign eval = win_q && win_cnt_q == WIN_LAST && !start_pulse;
  always_ff @(posedge clk) begin
    if (rst) begin
      win_q <= 1'b0;
      win_cnt_q <= 29'h00000000;
    end else if (start_pulse) begin
      win_q <= 1'b1;
      win_cnt_q <= 29'h00000000;
    end else if (eval) begin
      win_q <= 1'b0;
    end else if (win_q) begin
      win_cnt_q <= 29'(win_cnt_q + 29'h1);
    end
  end

  // Sightings latched inside the window
  logic ret_seen_q, fls_seen_q;
  logic [2:0] thr_seen_q, ect_seen_q;
  always_ff @(posedge clk) begin
    if (rst || start_pulse) begin
      ret_seen_q <= 1'b0;
      fls_seen_q <= 1'b0;
      thr_seen_q <= 3'h0;
      ect_seen_q <= 3'h0;
    end else if (win_q) begin
      ret_seen_q <= ret_seen_q | sync2_q[1];
      if (win_cnt_q < FLS_LIM)
        fls_seen_q <= fls_seen_q | sync2_q[2];
      thr_seen_q <= thr_seen_q | sync2_q[5:3];
      // Coolant order: sensor, J1939, J1587
      ect_seen_q <= ect_seen_q | sync2_q[8:6];
    end
  end

  // Tool reset held pending so it never collides with an evaluation
  logic rst_all_pend_q, rst_ret_pend_q, apply_all, apply_ret;
  assign apply_all = rst_all_pend_q & ~eval;
  assign apply_ret = (rst_ret_pend_q | rst_all_pend_q) & ~eval;
  always_ff @(posedge clk) begin
    if (rst) begin
      rst_all_pend_q <= 1'b0;
      rst_ret_pend_q <= 1'b0;
    end else begin
      // Shift learning clear is deliberately not decoded here
      rst_all_pend_q <= reset_all_cmd | (rst_all_pend_q & eval);
      rst_ret_pend_q <= reset_retarder_cmd | (rst_ret_pend_q & eval);
    end
  end

  // Override writes; evaluation has precedence in the same cycle
  logic ovr_ret, ovr_fls, ovr_thr, ovr_ect;
  assign ovr_ret = customer_constant_write &&
                   customer_constant_item == ITEM_RETARDER;
  assign ovr_fls = customer_constant_write &&
                   customer_constant_item == ITEM_FLS;
  assign ovr_thr = customer_constant_write &&
                   customer_constant_item == ITEM_THROTTLE;
  assign ovr_ect = customer_constant_write &&
                   customer_constant_item == ITEM_COOLANT;

  // General start counter for the first-group items
  logic [5:0] start_cnt_q;
  always_ff @(posedge clk) begin
    if (rst || apply_all) start_cnt_q <= CNT6_RST;
    else if (eval && start_cnt_q < START_LIMIT)
      start_cnt_q <= 6'(start_cnt_q + 6'h1);
  end

  // Retarder detection
  logic [5:0] ret_cnt_q;
  logic [2:0] ret_cons_q;
  logic [2:0] ret_cons_d;
  assign ret_cons_d = ret_seen_q ? 3'(ret_cons_q + 3'h1) : CNT3_RST;
  always_ff @(posedge clk) begin
    if (rst || apply_ret) begin
      ret_cnt_q <= CNT6_RST;
      ret_cons_q <= CNT3_RST;
      retarder_present <= 1'b0;
      retarder_done <= 1'b0;
    end else if (eval && !retarder_done) begin
      ret_cnt_q <= 6'(ret_cnt_q + 6'h1);
      ret_cons_q <= ret_cons_d;
      if (ret_cons_d == RET_CONSEC) begin
        retarder_present <= 1'b1;
        retarder_done <= 1'b1;
      end else if (6'(ret_cnt_q + 6'h1) == RET_LIMIT) begin
        retarder_present <= 1'b0;
        retarder_done <= 1'b1;
      end
    end else if (ovr_ret && !eval) begin
      retarder_present <= customer_constant_value[0];
      retarder_done <= 1'b1;
    end
  end

  // Level sensor detection; diagnostics follow the present mark
  always_ff @(posedge clk) begin
    if (rst || apply_all) begin
      fls_present <= 1'b0;
      fls_done <= 1'b0;
    end else if (eval && !fls_done) begin
      if (fls_seen_q) begin
        fls_present <= 1'b1;
        fls_done <= 1'b1;
      end else if (6'(start_cnt_q + 6'h1) >= START_LIMIT) begin
        fls_done <= 1'b1;
      end
    end else if (ovr_fls && !eval) begin
      fls_present <= customer_constant_value[0];
      fls_done <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) fls_diag_enable <= 1'b0;
    else fls_diag_enable <= fls_present;
  end

  // Throttle detection: unlimited until a flag, then a countdown
  logic [2:0] thr_cons_q [3];
  logic [2:0] thr_flag_q, thr_flag_d;
  logic [3:0] thr_cd_q;
  always_comb begin
    for (int i = 0; i < 3; i++)
      thr_flag_d[i] = thr_flag_q[i] |
        (cons_step(thr_cons_q[i], thr_seen_q[i]) == CONF_CONSEC);
  end
  always_ff @(posedge clk) begin
    if (rst || apply_all) begin
      for (int i = 0; i < 3; i++) thr_cons_q[i] <= CNT3_RST;
      thr_flag_q <= 3'h0;
      thr_cd_q <= CNT4_RST;
      throttle_source <= SRC_NONE;
      throttle_done <= 1'b0;
    end else if (eval && !throttle_done) begin
      for (int i = 0; i < 3; i++)
        thr_cons_q[i] <= cons_step(thr_cons_q[i], thr_seen_q[i]);
      thr_flag_q <= thr_flag_d;
      if (thr_flag_q == 3'h0) begin
        // No flag yet: best source flagged now, else best seen this start
        throttle_source <= (thr_flag_d != 3'h0) ?
          pick_src(thr_flag_d) : pick_src(thr_seen_q);
        if (thr_flag_d != 3'h0) thr_cd_q <= THR_COUNTDOWN;
      end else begin
        throttle_source <= pick_src(thr_flag_d);
        thr_cd_q <= 4'(thr_cd_q - 4'h1);
        if (thr_cd_q == 4'h1) throttle_done <= 1'b1;
      end
    end else if (ovr_thr && !eval) begin
      throttle_source <= customer_constant_value;
      throttle_done <= 1'b1;
    end
  end

  // Coolant detection over a fixed group of starts
  logic [2:0] ect_cons_q [3];
  logic [2:0] ect_flag_q, ect_flag_d;
  always_comb begin
    for (int i = 0; i < 3; i++)
      ect_flag_d[i] = ect_flag_q[i] |
        (cons_step(ect_cons_q[i], ect_seen_q[i]) == CONF_CONSEC);
  end
  always_ff @(posedge clk) begin
    if (rst || apply_all) begin
      for (int i = 0; i < 3; i++) ect_cons_q[i] <= CNT3_RST;
      ect_flag_q <= 3'h0;
      coolant_source <= SRC_NONE;
      coolant_done <= 1'b0;
    end else if (eval && !coolant_done) begin
      for (int i = 0; i < 3; i++)
        ect_cons_q[i] <= cons_step(ect_cons_q[i], ect_seen_q[i]);
      ect_flag_q <= ect_flag_d;
      coolant_source <= (ect_flag_d != 3'h0) ?
        pick_src(ect_flag_d) : pick_src(ect_seen_q);
      if (6'(start_cnt_q + 6'h1) >= START_LIMIT)
        coolant_done <= 1'b1;
    end else if (ovr_ect && !eval) begin
      coolant_source <= customer_constant_value;
      coolant_done <= 1'b1;
    end
  end

  // Configuration id sensed during the first group of starts
  logic [1:0] id_level;
  assign id_level = sync2_q[9] ? CFG_LEVEL_A : sync2_q[11:10];
  always_ff @(posedge clk) begin
    if (rst) begin
      cal_level <= CFG_LEVEL_A;
      cal_missing_code <= 1'b0;
    end else if (eval && start_cnt_q < START_LIMIT) begin
      if (32'(id_level) < CAL_LEVELS) begin
        cal_level <= id_level;
      end else begin
        cal_missing_code <= 1'b1;
      end
    end
  end

  // Window flag to the outside, registered
  always_ff @(posedge clk) begin
    if (rst) window_active <= 1'b0;
    else window_active <= win_q;
  end
  // Start counters and done marks clear only on rst or a tool reset
endmodule // pad_autodetect

// [hw/pad_pkg.sv]
// Constants shared by the peripheral autodetect logic
package pad_pkg;
  // Clock rate in kHz
  localparam int unsigned CLK_KHZ = 10000;
  // Per-start detection window and level-sensor window, in ms
  localparam int unsigned DETECT_WINDOW_MS = 30000;
  localparam int unsigned FLS_WINDOW_MS = 12500;
  // Cycle counts derived from the times (exact at this rate)
  localparam int unsigned DETECT_WINDOW_CYC = DETECT_WINDOW_MS * CLK_KHZ;
  localparam int unsigned FLS_WINDOW_CYC = FLS_WINDOW_MS * CLK_KHZ;
  // Start limits and consecutive counts
  localparam logic [5:0] START_LIMIT = 6'h19;
  localparam logic [5:0] RET_LIMIT = 6'h23;
  localparam logic [2:0] RET_CONSEC = 3'h3;
  localparam logic [2:0] CONF_CONSEC = 3'h5;
  localparam logic [3:0] THR_COUNTDOWN = 4'hF;
  // Source codes: 0 none, otherwise priority index plus one
  localparam logic [1:0] SRC_NONE = 2'h0;
  // Throttle: 1 analogue sensor, 2 J1587, 3 J1939
  // Coolant: 1 sensor, 2 J1939, 3 J1587
  // Override item select
  localparam logic [1:0] ITEM_RETARDER = 2'h0;
  localparam logic [1:0] ITEM_FLS = 2'h1;
  localparam logic [1:0] ITEM_THROTTLE = 2'h2;
  localparam logic [1:0] ITEM_COOLANT = 2'h3;
  // Configuration level decoded from the driver-tied line
  localparam logic [1:0] CFG_LEVEL_A = 2'h0;
  // Number of stored calibration levels
  localparam int unsigned NUM_CAL_LEVELS = 1;
  // Reset values
  localparam logic [5:0] CNT6_RST = 6'h00;
  localparam logic [2:0] CNT3_RST = 3'h0;
  localparam logic [3:0] CNT4_RST = 4'h0;
endpackage

// [testbench/pad_autodetect_assertions.sv]
// Port-level checks for the peripheral autodetect block
module pad_autodetect_checker
  import pad_pkg::*;
#(
  parameter int unsigned WIN_CYC = DETECT_WINDOW_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Start pin and tool commands
  input wire logic engine_start,
  input wire logic reset_all_cmd,
  input wire logic reset_retarder_cmd,
  input wire logic shift_learning_clear_command,
  input wire logic customer_constant_write,
  input wire logic [1:0] customer_constant_item,
  input wire logic [1:0] customer_constant_value,
  // Results
  input wire logic retarder_present,
  input wire logic retarder_done,
  input wire logic fls_present,
  input wire logic fls_done,
  input wire logic fls_diag_enable,
  input wire logic [1:0] throttle_source,
  input wire logic throttle_done,
  input wire logic [1:0] coolant_source,
  input wire logic coolant_done,
  input wire logic window_active
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] win_len_q;
  logic [1:0] tool_q;
  // Window length; saturates so a stuck window cannot wrap back to legal
  always_ff @(posedge clk) begin
    if (rst || !window_active)
      win_len_q <= 32'h0;
    else if (win_len_q != 32'hFFFFFFFF)
      win_len_q <= win_len_q + 32'h1;
  end
  // Writes and resets of the last two cycles; a reset acts one cycle late
  // and an evaluation may hold it back one cycle more
  always_ff @(posedge clk) begin
    tool_q <= {tool_q[0],
               customer_constant_write | reset_all_cmd | reset_retarder_cmd};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // A start edge on the pin, and a cycle outside any window with no reset-all or write now and no write or reset in the two cycles before
  sequence s_start;
    !engine_start ##1 engine_start;
  endsequence
  sequence s_idle;
    !window_active && !reset_all_cmd && !customer_constant_write
      && tool_q == 2'h0;
  endsequence
  property p_start_opens;
    s_start |-> ##[2:6] window_active;
  endproperty
  a_start_opens: assert property (p_start_opens) else $error("no window");
  property p_win_len;
    $fell(window_active) |-> win_len_q >= WIN_CYC - 1
      && win_len_q <= WIN_CYC + 1;
  endproperty
  a_win_len: assert property (p_win_len) else $error("window length");
  property p_ret_hold;
    retarder_done && !customer_constant_write && !reset_all_cmd
      && !reset_retarder_cmd && tool_q == 2'h0
      |=> retarder_done && $stable(retarder_present);
  endproperty
  a_ret_hold: assert property (p_ret_hold) else $error("retarder moved");
  property p_fls_diag;
    1'b1 |=> fls_diag_enable == $past(fls_present);
  endproperty
  a_fls_diag: assert property (p_fls_diag) else $error("level diag");
  property p_slc;
    s_idle and shift_learning_clear_command && !reset_retarder_cmd
      |=> $stable({retarder_present, retarder_done, fls_present, fls_done,
      throttle_source, throttle_done, coolant_source, coolant_done});
  endproperty
  a_slc: assert property (p_slc) else $error("learn clear moved");
  property p_rall;
    reset_all_cmd && !window_active |-> ##2 !retarder_done && !fls_done
      && !throttle_done && !coolant_done && throttle_source == SRC_NONE;
  endproperty
  a_rall: assert property (p_rall) else $error("reset all");
  property p_ovr;
    s_idle ##0 (1'b1 ##1 customer_constant_write
      && customer_constant_item == ITEM_THROTTLE && !window_active)
      |=> throttle_done && throttle_source == $past(customer_constant_value);
  endproperty
  a_ovr: assert property (p_ovr) else $error("override");
  property p_src_moves;
    $changed(throttle_source) |-> $past(window_active) || tool_q != 2'h0;
  endproperty
  a_src_moves: assert property (p_src_moves) else $error("source moved");
endmodule // pad_autodetect_checker

bind pad_autodetect pad_autodetect_checker #(.WIN_CYC(WIN_CYC)) i_chk (
  .clk(clk), .rst(rst), .engine_start(engine_start),
  .reset_all_cmd(reset_all_cmd), .reset_retarder_cmd(reset_retarder_cmd),
  .shift_learning_clear_command(shift_learning_clear_command),
  .customer_constant_write(customer_constant_write),
  .customer_constant_item(customer_constant_item),
  .customer_constant_value(customer_constant_value),
  .retarder_present(retarder_present), .retarder_done(retarder_done),
  .fls_present(fls_present), .fls_done(fls_done),
  .fls_diag_enable(fls_diag_enable), .throttle_source(throttle_source),
  .throttle_done(throttle_done), .coolant_source(coolant_source),
  .coolant_done(coolant_done), .window_active(window_active)
);

// [testbench/pad_autodetect_bench.sv]
// Self-checking bench for the peripheral autodetect block
module pad_autodetect_bench
  import pad_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, tied, ra, rr, slc, ccw, st;
  logic rp, rd, fp, fd, fde, td, cd, cm, wa;
  logic [1:0] id, cci, ccv, ts, cs, cl;
  logic [7:0] seen;
  int num_errors = 0;
  int comparisons = 0;
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  pad_far i_far (.clk(clk), .st(st), .seen(seen));
  // Short windows keep the run brief; one stored calibration level
  pad_autodetect #(.WIN_CYC(40), .FLS_CYC(20), .CAL_LEVELS(1)) i_dut (
    .clk(clk), .rst(rst), .engine_start(st),
    .retarder_pressure_solenoid_seen(seen[7]),
    .fluid_level_sensor_above(seen[6]),
    .throttle_position_sensor_seen(seen[5]),
    .throttle_j1587_seen(seen[4]), .throttle_j1939_seen(seen[3]),
    .coolant_sensor_seen(seen[2]), .coolant_j1939_seen(seen[1]),
    .coolant_j1587_seen(seen[0]), .hardware_config_id_hsd_tied(tied),
    .hardware_config_id(id), .reset_all_cmd(ra), .reset_retarder_cmd(rr),
    .shift_learning_clear_command(slc), .customer_constant_write(ccw),
    .customer_constant_item(cci), .customer_constant_value(ccv),
    .retarder_present(rp), .retarder_done(rd), .fls_present(fp),
    .fls_done(fd), .fls_diag_enable(fde), .throttle_source(ts),
    .throttle_done(td), .coolant_source(cs), .coolant_done(cd),
    .cal_level(cl), .cal_missing_code(cm), .window_active(wa)
  );
  // All results but the window flag in one word: flags, then throttle, coolant, cal codes
  task automatic chk(input logic [13:0] exp);
    logic [13:0] got;
    got = {rp, rd, fp, fd, fde, td, cd, cm, ts, cs, cl};
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t status %h exp %h", $time, got, exp);
    end
  endtask
  // Tool command pulse: {all, retarder, learn clear, write}
  task automatic tool(input logic [3:0] c, input logic [1:0] it,
                      input logic [1:0] v);
    @(negedge clk);
    {ra, rr, slc, ccw} = c;
    cci = it;
    ccv = v;
    @(negedge clk);
    {ra, rr, slc, ccw} = 4'h0;
    repeat (2) @(negedge clk);
  endtask
  task automatic summarize();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    // Id pins off level A while tied, so the tie must win
    {tied, id, ra, rr, slc, ccw, cci, ccv} = 11'h600;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk(14'h0000);
    // Retarder gap at start 3, level sensor late until start 8
    for (int i = 1; i <= 8; i++) begin
      i_far.run({i != 3, 7'h5E}, i != 8);
      case (i)
        1: chk(14'h0024);
        5: chk(14'h0024);
        6: chk(14'h3024);
        8: chk(14'h3E24);
        default: ;
      endcase
    end
    tool(4'h2, 2'h0, 2'h0);
    chk(14'h3E24);
    tool(4'h4, 2'h0, 2'h0);
    chk(14'h0E24);
    tool(4'h1, ITEM_THROTTLE, 2'h3);
    chk(14'h0F34);
    tool(4'h1, ITEM_RETARDER, 2'h1);
    tool(4'h1, ITEM_COOLANT, 2'h3);
    tool(4'h1, ITEM_FLS, 2'h0);
    chk(14'h35BC);
    tool(4'h8, 2'h0, 2'h0);
    chk(14'h0000);
    // Unstored id level; tps joins late; two coolant buses at once
    tied = 1'b0;
    id = 2'h2;
    for (int i = 1; i <= 35; i++) begin
      i_far.run({2'h0, i >= 3, 5'h0B}, 1'b0);
      case (i)
        1: chk(14'h0078);
        3: chk(14'h0058);
        5: chk(14'h0078);
        7: chk(14'h0058);
        19: chk(14'h0058);
        20: chk(14'h0158);
        24: chk(14'h0158);
        25: chk(14'h05D8);
        34: chk(14'h05D8);
        35: chk(14'h15D8);
        default: ;
      endcase
    end
    summarize();
  end
  // Hang guard at about twice the expected run length
  initial begin
    repeat (6000) @(posedge clk);
    num_errors++;
    summarize();
  end
endmodule // pad_autodetect_bench

// [testbench/pad_far.sv]
// Far-side model: engine start pin and per-start sighting levels
module pad_far (
  // Clock
  input wire logic clk,
  // Start pin and sightings: ret, level, tps, t87, t39, cs, c39, c87
  output logic st,
  output logic [7:0] seen
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    st = 1'b0;
    seen = 8'h00;
  end
  // One start; late holds the level sensor back past its short window
  task automatic run(input logic [7:0] p, input logic late);
    @(negedge clk);
    st = 1'b1;
    seen = late ? (p & 8'hBF) : p;
    repeat (30) @(negedge clk);
    seen[6] = p[6];
    // Lines fall well after the window, spacing stays above its length
    repeat (25) @(negedge clk);
    st = 1'b0;
    seen = 8'h00;
    repeat (3) @(negedge clk);
  endtask
endmodule // pad_far
